// *** mss_pkg.sv ***
// Constants and carrier types of the motor start supervision block.
package mss_pkg;

	// Time base: a 100 ms tick derived from the 100 MHz clock.
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned TICK_MS     = 100;
	localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
	localparam logic [3:0]  TICKS_PER_S = 4'hA;
	localparam logic [15:0] SEC_PER_MIN = 16'h003C;

	// Depth of the start time history used by the starts-per-period window.
	localparam int unsigned HIST_DEPTH = 64;

	// Register byte addresses.
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_T_START = 8'h04;
	localparam logic [7:0] A_T_LOCK  = 8'h08;
	localparam logic [7:0] A_T_STALL = 8'h0C;
	localparam logic [7:0] A_DLY     = 8'h10;
	localparam logic [7:0] A_ALLOW   = 8'h14;
	localparam logic [7:0] A_PERIOD  = 8'h18;
	localparam logic [7:0] A_CPERIOD = 8'h1C;
	localparam logic [7:0] A_COLD    = 8'h20;
	localparam logic [7:0] A_HOT     = 8'h24;
	localparam logic [7:0] A_HOTLVL  = 8'h28;
	localparam logic [7:0] A_STATUS  = 8'h2C;
	localparam logic [7:0] A_IRQ_ST  = 8'h30;
	localparam logic [7:0] A_IRQ_MSK = 8'h34;
	localparam logic [7:0] A_REMAIN  = 8'h38;
	localparam logic [7:0] A_LOCKOUT = 8'h3C;
	localparam logic [7:0] A_CNT0    = 8'h40;
	localparam logic [7:0] A_CNT_END = 8'h58;

	// Control register fields.
	localparam int CTRL_LR     = 0;
	localparam int CTRL_SR     = 1;
	localparam int CTRL_PERIOD = 2;
	localparam int CTRL_CONSEC = 3;
	localparam int CTRL_BSEL   = 4;

	// Event indices, shared by the interrupt status, mask and counter registers.
	localparam int EV_TRIP  = 0;
	localparam int EV_EXC   = 1;
	localparam int EV_LOCK  = 2;
	localparam int EV_STALL = 3;
	localparam int EV_INH   = 4;
	localparam int EV_START = 5;
	localparam int NUM_EV   = 6;

	// Settings carried as one word; times in 100 ms, delays in s, periods in min.
	typedef struct packed {
		logic [2:0]  block_sel;
		logic        consec_en;
		logic        period_en;
		logic        sr_en;
		logic        lr_en;
		logic [11:0] t_start;
		logic [11:0] t_lock;
		logic [11:0] t_stall;
		logic [12:0] dly;
		logic [5:0]  allow;
		logic [8:0]  period;
		logic [6:0]  cperiod;
		logic [2:0]  cold;
		logic [2:0]  hot;
		logic [6:0]  hot_lvl;
	} mss_cfg_s;

	localparam mss_cfg_s CFG_RST = '{block_sel: 3'h0, consec_en: 1'b1, period_en: 1'b1,
		sr_en: 1'b1, lr_en: 1'b1, t_start: 12'h032, t_lock: 12'h01E, t_stall: 12'h00A,
		dly: 13'h0005, allow: 6'h0A, period: 9'h03C, cperiod: 7'h0A, cold: 3'h2,
		hot: 3'h1, hot_lvl: 7'h32};

	// Latched locked-rotor indications.
	typedef struct packed {
		logic trip;
		logic exc;
		logic lock;
		logic stall;
	} mss_lr_s;

endpackage : mss_pkg

// *** mss_top.sv ***
// Motor start supervision: locked-rotor timing and start-rate inhibit.
//
// Notes on behaviour
// - With rotation, starting held longer than start-up time flags excessive start.
// - Without rotation, starting held longer than locked start time flags locked start.
// - Stalling held longer than stall time flags a stall.
// - Locked-rotor trip rises in the same cycle as any of the three conditions.
// - Stopped machine clears all locked-rotor outputs and duration timers.
// - Start-up current taken as maximum, so start-up time limit is a constant.
// - Separate event counters for trip, excessive start, locked start and stall.
// - Any reached enabled start-rate criterion blocks the breaker close command.
// - Minimum delay between two starts, 0 to 5400 s, default 5 s.
// - Starts within a sliding period limited to 1 to 60, period 1 to 360 min.
// - Each start-rate criterion has its own enable; they may act together. The spacing delay has none and acts whenever start-rate supervision is on.
// - Cold starts counted in consecutive period; inhibit when cold allowance reached.
// - Hot starts counted in consecutive period; inhibit when hot allowance reached.
// - Hot or cold state comes from thermal overload, valid only when it is enabled.
// - Inhibit may be blocked by one selectable source: none or variable 1 to 4.
// - Machine is hot when thermal level exceeds the hot state threshold.
// - Report remaining permitted starts and remaining lockout time in seconds.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps

module mss_top #(
	parameter int unsigned TICK_CYCLES = mss_pkg::TICK_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	input  wire logic        STARTING,
	input  wire logic        STALLING,
	input  wire logic        STOPPED,
	input  wire logic        ROTATION,
	input  wire logic [3:0]  BLOCK_VAR,
	input  wire logic        THERM_EN,
	input  wire logic [6:0]  THERM_LVL,
	output logic             LR_TRIP,
	output logic             EXC_START,
	output logic             LOCK_START,
	output logic             STALL_TRIP,
	output logic             CLOSE_INHIBIT,
	output logic             HOT_STATE,
	output logic             IRQ
);
	import mss_pkg::*;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and time base.

	logic [4:0]  pin_m;
	logic [4:0]  pin_s;
	logic        rot;
	logic [23:0] div_cnt;
	logic [23:0] next_div_cnt;
	logic [3:0]  sub_cnt;
	logic [3:0]  next_sub_cnt;
	logic        tick;
	logic        next_tick;
	logic        sec;
	logic        next_sec;
	logic [15:0] now_s;
	logic [15:0] next_now_s;

	// Rotation and block variables are relay pins; bit 0 is rotation.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			pin_m <= '0;
			pin_s <= '0;
		end else begin
			pin_m <= {BLOCK_VAR, ROTATION};
			pin_s <= pin_m;
		end
	end
	assign rot = pin_s[0];

	// One divider gives the 100 ms tick and the 1 s step for every timer.
	always_comb begin
		next_div_cnt = div_cnt + 24'h1;
		next_tick    = 1'b0;
		next_sub_cnt = sub_cnt;
		next_sec     = 1'b0;
		next_now_s   = now_s;
		if (div_cnt == 24'(TICK_CYCLES - 1)) begin
			next_div_cnt = '0;
			next_tick    = 1'b1;
			if (sub_cnt == TICKS_PER_S - 4'h1) begin
				next_sub_cnt = '0;
				next_sec     = 1'b1;
				next_now_s   = now_s + 16'h1;
			end else begin
				next_sub_cnt = sub_cnt + 4'h1;
			end
		end
	end

	// Time base registers.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			div_cnt <= '0;
			sub_cnt <= '0;
			tick    <= 1'b0;
			sec     <= 1'b0;
			now_s   <= '0;
		end else begin
			div_cnt <= next_div_cnt;
			sub_cnt <= next_sub_cnt;
			tick    <= next_tick;
			sec     <= next_sec;
			now_s   <= next_now_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Locked-rotor supervision.

	mss_cfg_s    cfg;
	mss_lr_s     lr;
	mss_lr_s     next_lr;
	logic [11:0] start_t;
	logic [11:0] next_start_t;
	logic [11:0] stall_t;
	logic [11:0] next_stall_t;

	// Timers count whole ticks while the indication stays set and saturate.
	// The start-up limit is a plain constant setting: no current weighting.
	always_comb begin
		next_lr      = lr;
		next_start_t = start_t;
		next_stall_t = stall_t;
		if (!STARTING) begin
			next_start_t = '0;
		end else if (tick && start_t != 12'hFFF) begin
			next_start_t = start_t + 12'h1;
		end
		if (!STALLING) begin
			next_stall_t = '0;
		end else if (tick && stall_t != 12'hFFF) begin
			next_stall_t = stall_t + 12'h1;
		end
		if (cfg.lr_en && STARTING && rot && start_t > cfg.t_start) begin
			next_lr.exc = 1'b1;
		end
		if (cfg.lr_en && STARTING && !rot && start_t > cfg.t_lock) begin
			next_lr.lock = 1'b1;
		end
		if (cfg.lr_en && STALLING && stall_t > cfg.t_stall) begin
			next_lr.stall = 1'b1;
		end
		next_lr.trip = next_lr.exc | next_lr.lock | next_lr.stall;
		if (STOPPED) begin
			next_lr      = '0;
			next_start_t = '0;
			next_stall_t = '0;
		end
	end

	// Indications latch until the machine is seen stopped.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			lr      <= '0;
			start_t <= '0;
			stall_t <= '0;
		end else begin
			lr      <= next_lr;
			start_t <= next_start_t;
			stall_t <= next_stall_t;
		end
	end

	rot_exc_a: assert property ($rose(lr.exc) |-> $past(rot && STARTING));
	lock_start_a: assert property ($rose(lr.lock) |-> $past(!rot && start_t > cfg.t_lock));
	stall_time_a: assert property ($rose(lr.stall) |-> $past(stall_t > cfg.t_stall));
	trip_same_a: assert property (lr.trip == (lr.exc || lr.lock || lr.stall));
	stop_clear_a: assert property (STOPPED |=> !lr.trip && start_t == 12'h0);

	////////////////////////////////////////////////////////////////////////////////
	// Start history for the sliding starts-per-period window.

	logic                  start_q;
	logic                  start_edge;
	logic [15:0]           hist_t [HIST_DEPTH];
	logic [HIST_DEPTH-1:0] hist_v;
	logic [HIST_DEPTH-1:0] next_hist_v;
	logic [5:0]            wr_ptr;
	logic [5:0]            next_wr_ptr;
	logic [5:0]            scan_ptr;
	logic [6:0]            act_cnt;
	logic [6:0]            next_act_cnt;
	logic [15:0]           age;

	assign start_edge = STARTING && !start_q;

	// One entry is aged per cycle; a full sweep takes far less than a second,
	// so no live stamp can alias against the 16-bit seconds counter.
	always_comb begin
		next_hist_v  = hist_v;
		next_act_cnt = act_cnt;
		next_wr_ptr  = wr_ptr;
		age          = now_s - hist_t[scan_ptr];
		if (hist_v[scan_ptr] && age >= 16'(cfg.period) * SEC_PER_MIN) begin
			next_hist_v[scan_ptr] = 1'b0;
			next_act_cnt          = act_cnt - 7'h1;
		end
		if (start_edge && cfg.period_en) begin
			if (!next_hist_v[wr_ptr]) begin
				next_act_cnt = next_act_cnt + 7'h1;
			end
			next_hist_v[wr_ptr] = 1'b1;
			next_wr_ptr         = wr_ptr + 6'h1;
		end
	end

	// History control registers.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			start_q  <= 1'b0;
			hist_v   <= '0;
			act_cnt  <= '0;
			wr_ptr   <= '0;
			scan_ptr <= '0;
		end else begin
			start_q  <= STARTING;
			hist_v   <= next_hist_v;
			act_cnt  <= next_act_cnt;
			wr_ptr   <= next_wr_ptr;
			scan_ptr <= scan_ptr + 6'h1;
		end
	end

	// Stamp memory has no reset; the valid bits guard it.
	always_ff @(posedge CLK) begin
		if (start_edge && cfg.period_en) begin
			hist_t[wr_ptr] <= now_s;
		end
	end

	hist_bound_a: assert property (act_cnt <= 7'(HIST_DEPTH));

	////////////////////////////////////////////////////////////////////////////////
	// Start-rate criteria and inhibit.

	logic [12:0] dly_rem;
	logic [12:0] next_dly_rem;
	logic [12:0] win_rem;
	logic [12:0] next_win_rem;
	logic [2:0]  cold_n;
	logic [2:0]  next_cold_n;
	logic [2:0]  hot_n;
	logic [2:0]  next_hot_n;
	logic        hot;
	logic        blocked;
	logic        crit_dly;
	logic        crit_per;
	logic        crit_con;
	logic        inh;
	logic        next_inh;
	logic [2:0]  remain;
	logic [2:0]  next_remain;
	logic [12:0] lockout;
	logic [12:0] next_lockout;

	// Without thermal overload enabled the machine is always taken as cold.
	assign hot      = THERM_EN && THERM_LVL > cfg.hot_lvl;
	assign blocked  = cfg.block_sel != 3'h0 && cfg.block_sel <= 3'h4
		&& pin_s[cfg.block_sel];
	assign crit_dly = dly_rem != 13'h0;
	assign crit_per = cfg.period_en && act_cnt >= {1'b0, cfg.allow};
	assign crit_con = cfg.consec_en && (cold_n >= cfg.cold || hot_n >= cfg.hot);

	// Timers step on the 1 s pulse; a new start reloads the spacing timer and
	// opens a consecutive window when none is running.
	always_comb begin
		next_dly_rem = dly_rem;
		next_win_rem = win_rem;
		next_cold_n  = cold_n;
		next_hot_n   = hot_n;
		if (sec && dly_rem != 13'h0) begin
			next_dly_rem = dly_rem - 13'h1;
		end
		if (start_edge) begin
			next_dly_rem = cfg.dly;
		end
		if (sec && win_rem != 13'h0) begin
			next_win_rem = win_rem - 13'h1;
			if (win_rem == 13'h1) begin
				next_cold_n = '0;
				next_hot_n  = '0;
			end
		end
		if (start_edge && cfg.consec_en) begin
			if (next_win_rem == 13'h0) begin
				next_win_rem = 13'(16'(cfg.cperiod) * SEC_PER_MIN);
			end
			if (hot && next_hot_n != 3'h7) begin
				next_hot_n = next_hot_n + 3'h1;
			end else if (!hot && next_cold_n != 3'h7) begin
				next_cold_n = next_cold_n + 3'h1;
			end
		end
		next_inh = cfg.sr_en && !blocked && (crit_dly || crit_per || crit_con);
		if (hot) begin
			next_remain = cfg.hot > hot_n ? cfg.hot - hot_n : 3'h0;
		end else begin
			next_remain = cfg.cold > cold_n ? cfg.cold - cold_n : 3'h0;
		end
		// Lockout covers the spacing and consecutive timers; the sliding
		// window has no single expiry time and is not included.
		next_lockout = dly_rem;
		if (crit_con && win_rem > dly_rem) begin
			next_lockout = win_rem;
		end
	end

	// Start-rate registers.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			dly_rem <= '0;
			win_rem <= '0;
			cold_n  <= '0;
			hot_n   <= '0;
			inh     <= 1'b0;
			remain  <= '0;
			lockout <= '0;
		end else begin
			dly_rem <= next_dly_rem;
			win_rem <= next_win_rem;
			cold_n  <= next_cold_n;
			hot_n   <= next_hot_n;
			inh     <= next_inh;
			remain  <= next_remain;
			lockout <= next_lockout;
		end
	end

	dly_load_a: assert property (start_edge |=> dly_rem == $past(cfg.dly));
	block_wins_a: assert property (blocked || !cfg.sr_en |=> !inh);
	inhibit_set_a: assert property (cfg.sr_en && !blocked && crit_dly |=> inh);
	window_end_a: assert property (sec && win_rem == 13'h1 && !start_edge
		|=> cold_n == 3'h0 && hot_n == 3'h0);

	////////////////////////////////////////////////////////////////////////////////
	// Register file, event counters and interrupt.

	mss_cfg_s           next_cfg;
	logic [NUM_EV-1:0]  ev;
	logic [NUM_EV-1:0]  irq_st;
	logic [NUM_EV-1:0]  next_irq_st;
	logic [NUM_EV-1:0]  irq_msk;
	logic [NUM_EV-1:0]  next_irq_msk;
	logic [15:0]        evt_cnt [NUM_EV];
	logic [15:0]        next_evt_cnt [NUM_EV];
	logic [31:0]        rdata;
	logic [31:0]        next_rdata;
	logic               irq;
	logic               next_irq;
	logic [7:0]         cnt_off;

	// Events are rising edges of the latched indications, of the inhibit and of the starting input.
	assign ev[EV_TRIP]  = next_lr.trip && !lr.trip;
	assign ev[EV_EXC]   = next_lr.exc && !lr.exc;
	assign ev[EV_LOCK]  = next_lr.lock && !lr.lock;
	assign ev[EV_STALL] = next_lr.stall && !lr.stall;
	assign ev[EV_INH]   = next_inh && !inh;
	assign ev[EV_START] = start_edge;
	assign cnt_off      = ADDR - A_CNT0;

	// Writes, write-one-to-clear status with set winning, and the read mux.
	always_comb begin
		next_cfg     = cfg;
		next_irq_msk = irq_msk;
		next_irq_st  = irq_st;
		for (int i = 0; i < NUM_EV; i++) begin
			next_evt_cnt[i] = evt_cnt[i] + {15'h0, ev[i]};
		end
		if (WR) begin
			unique case (ADDR)
				A_CTRL: begin
					next_cfg.lr_en     = WDATA[CTRL_LR];
					next_cfg.sr_en     = WDATA[CTRL_SR];
					next_cfg.period_en = WDATA[CTRL_PERIOD];
					next_cfg.consec_en = WDATA[CTRL_CONSEC];
					next_cfg.block_sel = WDATA[CTRL_BSEL+:3];
				end
				A_T_START: next_cfg.t_start = WDATA[11:0];
				A_T_LOCK:  next_cfg.t_lock  = WDATA[11:0];
				A_T_STALL: next_cfg.t_stall = WDATA[11:0];
				A_DLY:     next_cfg.dly     = WDATA[12:0];
				A_ALLOW:   next_cfg.allow   = WDATA[5:0];
				A_PERIOD:  next_cfg.period  = WDATA[8:0];
				A_CPERIOD: next_cfg.cperiod = WDATA[6:0];
				A_COLD:    next_cfg.cold    = WDATA[2:0];
				A_HOT:     next_cfg.hot     = WDATA[2:0];
				A_HOTLVL:  next_cfg.hot_lvl = WDATA[6:0];
				A_IRQ_ST:  next_irq_st      = irq_st & ~WDATA[NUM_EV-1:0];
				A_IRQ_MSK: next_irq_msk     = WDATA[NUM_EV-1:0];
				default: begin
				end
			endcase
		end
		next_irq_st = next_irq_st | ev;
		next_irq    = |(next_irq_st & next_irq_msk);
		next_rdata  = '0;
		if (RD) begin
			unique case (ADDR)
				A_CTRL: begin
					next_rdata[CTRL_LR]       = cfg.lr_en;
					next_rdata[CTRL_SR]       = cfg.sr_en;
					next_rdata[CTRL_PERIOD]   = cfg.period_en;
					next_rdata[CTRL_CONSEC]   = cfg.consec_en;
					next_rdata[CTRL_BSEL+:3]  = cfg.block_sel;
				end
				A_T_START: next_rdata[11:0] = cfg.t_start;
				A_T_LOCK:  next_rdata[11:0] = cfg.t_lock;
				A_T_STALL: next_rdata[11:0] = cfg.t_stall;
				A_DLY:     next_rdata[12:0] = cfg.dly;
				A_ALLOW:   next_rdata[5:0]  = cfg.allow;
				A_PERIOD:  next_rdata[8:0]  = cfg.period;
				A_CPERIOD: next_rdata[6:0]  = cfg.cperiod;
				A_COLD:    next_rdata[2:0]  = cfg.cold;
				A_HOT:     next_rdata[2:0]  = cfg.hot;
				A_HOTLVL:  next_rdata[6:0]  = cfg.hot_lvl;
				A_STATUS:  next_rdata[5:0]  = {hot, inh, lr.stall, lr.lock, lr.exc, lr.trip};
				A_IRQ_ST:  next_rdata[5:0]  = irq_st;
				A_IRQ_MSK: next_rdata[5:0]  = irq_msk;
				A_REMAIN:  next_rdata[2:0]  = remain;
				A_LOCKOUT: next_rdata[12:0] = lockout;
				default: begin
					if (ADDR >= A_CNT0 && ADDR < A_CNT_END && ADDR[1:0] == 2'h0) begin
						next_rdata[15:0] = evt_cnt[cnt_off[4:2]];
					end
				end
			endcase
		end
	end

	// Register file state.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cfg     <= CFG_RST;
			irq_st  <= '0;
			irq_msk <= '0;
			rdata   <= '0;
			irq     <= 1'b0;
			for (int i = 0; i < NUM_EV; i++) begin
				evt_cnt[i] <= '0;
			end
		end else begin
			cfg     <= next_cfg;
			irq_st  <= next_irq_st;
			irq_msk <= next_irq_msk;
			rdata   <= next_rdata;
			irq     <= next_irq;
			for (int i = 0; i < NUM_EV; i++) begin
				evt_cnt[i] <= next_evt_cnt[i];
			end
		end
	end

	sequence start_rise_s;
		!STARTING ##1 STARTING;
	endsequence

	property start_count_p;
		start_rise_s |=> evt_cnt[EV_START] == $past(evt_cnt[EV_START]) + 16'h1;
	endproperty

	start_count_a: assert property (start_count_p);
	exc_count_a: assert property ($rose(lr.exc)
		|-> evt_cnt[EV_EXC] == $past(evt_cnt[EV_EXC]) + 16'h1);

	logic remain_hot;

	// Outputs come straight from their flip-flops.
	assign RDATA         = rdata;
	assign LR_TRIP       = lr.trip;
	assign EXC_START     = lr.exc;
	assign LOCK_START    = lr.lock;
	assign STALL_TRIP    = lr.stall;
	assign CLOSE_INHIBIT = inh;
	assign HOT_STATE     = remain_hot;
	assign IRQ           = irq;

	// Hot state is registered for the output pin.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			remain_hot <= 1'b0;
		end else begin
			remain_hot <= hot;
		end
	end

endmodule : mss_top

// *** mss_motor.sv ***
// Behavioural breaker close path and rotation detector facing the supervision block.
`timescale 1ns/10ps

module mss_motor (
	input  wire logic clk,
	input  wire logic run,
	input  wire logic spin,
	input  wire logic inhibit,
	output logic      starting,
	output logic      rotation
);

	////////////////////////////////////////////////////////////////////////////////
	// A close command held while inhibited is refused, as a real breaker refuses it.
	// Neither line has a reset; both settle low at the first clock edge while run and spin are low.
	// Once closed, the feeder stays on until the command drops.
	always @(posedge clk) begin
		starting <= run & (starting | ~inhibit);
		rotation <= spin;
	end

endmodule : mss_motor

// *** testbench.sv ***
// Self-checking bench of the motor start supervision block.
`timescale 1ns/10ps

module testbench;
	import mss_pkg::*;

	localparam int TK = 20;
	localparam logic [31:0] RV [11] = '{32'h0F, 32'h32, 32'h1E, 32'h0A, 32'h05, 32'h0A,
		32'h3C, 32'h0A, 32'h02, 32'h01, 32'h32};
	localparam logic [3:0] LRX [3] = '{4'hC, 4'hA, 4'h9};

	logic        CLK        = 1'b0;
	logic        RESET      = 1'b1;
	logic [7:0]  ADDR       = 8'h00;
	logic [31:0] WDATA      = 32'h0;
	logic        WR         = 1'b0;
	logic        RD         = 1'b0;
	logic        STALLING   = 1'b0;
	logic        STOPPED    = 1'b0;
	logic [3:0]  BLOCK_VAR  = 4'h0;
	logic        THERM_EN   = 1'b0;
	logic [6:0]  THERM_LVL  = 7'h00;
	logic        run        = 1'b0;
	logic        spin       = 1'b0;
	logic [31:0] RDATA;
	logic        STARTING;
	logic        ROTATION;
	wire  [3:0]  lr;
	logic        CLOSE_INHIBIT;
	logic        HOT_STATE;
	logic        IRQ;
	int          num_errors = 0;
	int          checks     = 0;

	////////////////////////////////////////////////////////////////////////////////
	// A short tick keeps every timed flag within a few hundred clocks.
	always #5 CLK = ~CLK;

	mss_top #(.TICK_CYCLES(TK)) u_dut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .STARTING(STARTING), .STALLING(STALLING),
		.STOPPED(STOPPED), .ROTATION(ROTATION), .BLOCK_VAR(BLOCK_VAR), .THERM_EN(THERM_EN),
		.THERM_LVL(THERM_LVL), .LR_TRIP(lr[3]), .EXC_START(lr[2]), .LOCK_START(lr[1]),
		.STALL_TRIP(lr[0]), .CLOSE_INHIBIT(CLOSE_INHIBIT), .HOT_STATE(HOT_STATE), .IRQ(IRQ));

	mss_motor u_motor (.clk(CLK), .run(run), .spin(spin), .inhibit(CLOSE_INHIBIT),
		.starting(STARTING), .rotation(ROTATION));

	////////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
	endtask : cyc

	task automatic finish_test;
		if (num_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	task automatic chk_pin(input string n, input logic [3:0] e, input logic [3:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk_pin

	// Read strobe for one cycle; the word stands only in the cycle after it.
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] g;
		@(posedge CLK);
		ADDR <= a;
		RD   <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		@(posedge CLK);
		g = RDATA;
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value reg %h expected %h seen %h", a, e, g);
		end
	endtask : chk_reg

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge CLK);
		ADDR  <= a;
		WDATA <= v;
		WR    <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr

	// Reset also settles the pin synchronisers before the next test.
	task automatic rst;
		RESET     <= 1'b1;
		run       <= 1'b0;
		spin      <= 1'b0;
		STALLING  <= 1'b0;
		STOPPED   <= 1'b0;
		BLOCK_VAR <= 4'h0;
		THERM_EN  <= 1'b0;
		THERM_LVL <= 7'h00;
		cyc(10);
		RESET <= 1'b0;
		cyc(3);
	endtask : rst

	task automatic start;
		run <= 1'b1;
		cyc(8);
		run <= 1'b0;
		cyc(4);
	endtask : start

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the roughly 1300 clocks the tests need.
	initial begin
		#200us;
		num_errors++;
		finish_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		rst();
		for (int i = 0; i < 11; i++) begin
			chk_reg(8'(4 * i), RV[i]);
		end
		chk_reg(8'h80, 32'h0);
		chk_reg(8'h01, 32'h0);
		// Excessive start, locked start and stall, each with a three tick limit.
		for (int k = 0; k < 3; k++) begin
			rst();
			wr(A_T_START + 8'(4 * k), 32'h3);
			spin <= (k == 0);
			cyc(4);
			if (k == 2) begin
				STALLING <= 1'b1;
			end else begin
				run <= 1'b1;
			end
			cyc(60);
			chk_pin("flags early", 4'h0, lr);
			cyc(50);
			chk_pin("flags", LRX[k], lr);
			chk_reg(A_CNT0, 32'h1);
			chk_reg(A_CNT0 + 8'(4 * k + 4), 32'h1);
			STOPPED  <= 1'b1;
			run      <= 1'b0;
			STALLING <= 1'b0;
			cyc(3);
			chk_pin("flags stopped", 4'h0, lr);
		end
		// Spacing only: two seconds of inhibit after one start.
		rst();
		wr(A_CTRL, 32'h3);
		wr(A_DLY, 32'h2);
		start();
		chk_pin("inhibit", 4'h1, {3'h0, CLOSE_INHIBIT});
		chk_reg(A_LOCKOUT, 32'h2);
		cyc(170);
		chk_pin("inhibit", 4'h1, {3'h0, CLOSE_INHIBIT});
		cyc(250);
		chk_pin("inhibit", 4'h0, {3'h0, CLOSE_INHIBIT});
		wr(A_DLY, 32'h0);
		repeat (3) start();
		chk_pin("inhibit", 4'h0, {3'h0, CLOSE_INHIBIT});
		chk_reg(A_CNT0 + 8'h14, 32'h4);
		wr(A_CTRL, 32'h1);
		wr(A_DLY, 32'h5);
		start();
		chk_pin("inhibit", 4'h0, {3'h0, CLOSE_INHIBIT});
		// Starts per period, limit of two.
		rst();
		wr(A_CTRL, 32'h7);
		wr(A_DLY, 32'h0);
		wr(A_ALLOW, 32'h2);
		start();
		chk_pin("inhibit", 4'h0, {3'h0, CLOSE_INHIBIT});
		start();
		chk_pin("inhibit", 4'h1, {3'h0, CLOSE_INHIBIT});
		// Consecutive cold starts; the third close is refused by the breaker.
		rst();
		wr(A_CTRL, 32'hB);
		wr(A_DLY, 32'h0);
		start();
		chk_pin("inhibit", 4'h0, {3'h0, CLOSE_INHIBIT});
		chk_reg(A_REMAIN, 32'h1);
		start();
		chk_pin("inhibit", 4'h1, {3'h0, CLOSE_INHIBIT});
		chk_reg(A_REMAIN, 32'h0);
		start();
		chk_reg(A_CNT0 + 8'h14, 32'h2);
		// Hot state at the threshold and just above it.
		rst();
		THERM_EN  <= 1'b1;
		THERM_LVL <= 7'h32;
		cyc(3);
		chk_pin("hot", 4'h0, {3'h0, HOT_STATE});
		THERM_LVL <= 7'h33;
		cyc(3);
		chk_pin("hot", 4'h1, {3'h0, HOT_STATE});
		wr(A_CTRL, 32'hB);
		wr(A_DLY, 32'h0);
		chk_reg(A_REMAIN, 32'h1);
		start();
		chk_pin("inhibit", 4'h1, {3'h0, CLOSE_INHIBIT});
		THERM_EN <= 1'b0;
		cyc(3);
		chk_pin("hot", 4'h0, {3'h0, HOT_STATE});
		// Each block source holds the inhibit off until it drops.
		for (int s = 1; s < 5; s++) begin
			rst();
			wr(A_CTRL, 32'h0F | (s << 4));
			BLOCK_VAR <= 4'(1 << (s - 1));
			cyc(4);
			start();
			chk_pin("inhibit", 4'h0, {3'h0, CLOSE_INHIBIT});
			BLOCK_VAR <= 4'h0;
			cyc(6);
			chk_pin("inhibit", 4'h1, {3'h0, CLOSE_INHIBIT});
		end
		// Interrupt raised, masked and cleared.
		rst();
		start();
		chk_pin("irq", 4'h0, {3'h0, IRQ});
		chk_reg(A_IRQ_ST, 32'h30);
		chk_reg(A_STATUS, 32'h10);
		wr(A_IRQ_MSK, 32'h20);
		cyc(2);
		chk_pin("irq", 4'h1, {3'h0, IRQ});
		wr(A_IRQ_ST, 32'h20);
		cyc(2);
		chk_pin("irq", 4'h0, {3'h0, IRQ});
		chk_reg(A_IRQ_ST, 32'h10);
		finish_test();
	end

endmodule : testbench
